//--- hw/omc_cfg.svh
// Constants for the operating mode controller: offsets, fields, resets, waits.
// Assumes inclusion by bare name from the package and design modules.
`ifndef OMC_CFG_SVH
`define OMC_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define OMC_OFS_SLEEP_CMD     8'h15
`define OMC_OFS_MODE_CTRL     8'h17

// ****************************************
// Mode register fields
// ****************************************
`define OMC_BIT_RTC_CLR       2
`define OMC_BIT_RTC_EN        3
`define OMC_DIV_LO            4
`define OMC_DIV_HI            6
`define OMC_BIT_CLK_SEL       7

// ****************************************
// Reset values and magic code
// ****************************************
`define OMC_SLEEP_KEY         8'h5A
`define OMC_RST_DIV           3'h0
`define OMC_RST_RTC_EN        1'b1
`define OMC_RST_CLK_SEL       1'b1

// ****************************************
// Stabilisation waits, in oscillator cycles, and RTC divider width
// ****************************************
`define OMC_FAST_STAB_CYC     512
`define OMC_IRC_STAB_CYC      4
`define OMC_XTAL_STAB_CYC     1024
`define OMC_RTC_WIDTH         14

`endif

//--- hw/omc_ctrl.sv
// Operating mode controller: divider, clock select, RTC, sleep and wake.
// Assumes register strobes and oscillator ticks synchronous to clock.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "omc_cfg.svh"

module omc_ctrl
  import omc_pkg::*;
#(
  parameter int  STAB_W    = 11,
  parameter int  RTC_W     = `OMC_RTC_WIDTH,
  parameter bit  SLOW_XTAL = 1'b0
) (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic                fast_osc_tick,
  input  wire logic                slow_osc_tick,
  input  wire logic [7:0]          pad_levels,
  input  wire logic [7:0]          port_data,
  input  wire omc_pkg::omc_wake_t  wake_src,
  output omc_pkg::omc_clk_t        clk_ctrl,
  output logic                     fast_clk_tick,
  output omc_pkg::omc_mode_t       mode,
  output logic      [RTC_W-1:0]    rtc_count
);

  // Refused at elaboration: the wait counter must hold the longest wait
  if (STAB_W < 11 || RTC_W < 1) begin : g_param_check
    $error("omc_ctrl: STAB_W must be at least 11, RTC_W at least 1");
  end

  // ****************************************
  // Reset release synchroniser
  // ****************************************
  logic rst_meta_r, rst_sync_b;

  // Two-stage release so the rest of the block leaves reset cleanly
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************************************
  // Register file
  // ****************************************
  logic [2:0] div_r, div_nxt;
  logic       rtc_en_r, rtc_en_nxt;
  logic       clk_sel_r, clk_sel_nxt;
  logic       rtc_clr_r, rtc_clr_nxt;
  logic       sleep_req_r, sleep_req_nxt;
  logic [7:0] rdata_nxt;

  // Decode writes and reads; sleep register is write-only
  always_comb begin
    div_nxt       = div_r;
    rtc_en_nxt    = rtc_en_r;
    clk_sel_nxt   = clk_sel_r;
    rtc_clr_nxt   = 1'b0;
    sleep_req_nxt = 1'b0;
    rdata_nxt     = 8'h00;
    if (reg_wr && hit(reg_addr, `OMC_OFS_MODE_CTRL)) begin
      div_nxt     = reg_wdata[`OMC_DIV_HI:`OMC_DIV_LO];
      rtc_en_nxt  = reg_wdata[`OMC_BIT_RTC_EN];
      clk_sel_nxt = reg_wdata[`OMC_BIT_CLK_SEL];
      rtc_clr_nxt = !reg_wdata[`OMC_BIT_RTC_CLR];
    end
    // Only the exact key arms sleep; anything else is dropped
    if (reg_wr && hit(reg_addr, `OMC_OFS_SLEEP_CMD) &&
        reg_wdata == `OMC_SLEEP_KEY)
      sleep_req_nxt = 1'b1;
    if (reg_rd && hit(reg_addr, `OMC_OFS_MODE_CTRL)) begin
      rdata_nxt[`OMC_BIT_CLK_SEL]            = clk_sel_r;
      rdata_nxt[`OMC_DIV_HI:`OMC_DIV_LO]     = div_r;
      rdata_nxt[`OMC_BIT_RTC_EN]             = rtc_en_r;
      rdata_nxt[`OMC_BIT_RTC_CLR]            = 1'b1;
      rdata_nxt[1:0]                         = 2'(mode == OMC_SLOW ? 1 : 0);
    end
  end

  // Register stage of the register file
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      div_r       <= `OMC_RST_DIV;
      rtc_en_r    <= `OMC_RST_RTC_EN;
      clk_sel_r   <= `OMC_RST_CLK_SEL;
      rtc_clr_r   <= 1'b0;
      sleep_req_r <= 1'b0;
      reg_rdata   <= 8'h00;
    end else begin
      div_r       <= div_nxt;
      rtc_en_r    <= rtc_en_nxt;
      clk_sel_r   <= clk_sel_nxt;
      rtc_clr_r   <= rtc_clr_nxt;
      sleep_req_r <= sleep_req_nxt;
      reg_rdata   <= rdata_nxt;
    end
  end

  // ****************************************
  // Fast clock divider
  // ****************************************
  logic [6:0] fdiv_r, fdiv_nxt;
  logic       ftick_nxt;
  logic [6:0] div_mask;

  // Power of two mask: code n gives a tick every 2^n oscillator ticks
  assign div_mask = 7'((8'h01 << div_r) - 8'h01);

  // Divide only while the fast oscillator is running for the CPU
  always_comb begin
    fdiv_nxt  = fdiv_r;
    ftick_nxt = 1'b0;
    if (mode == OMC_NORMAL && fast_osc_tick) begin
      if ((fdiv_r & div_mask) == div_mask) begin
        fdiv_nxt  = 7'h00;
        ftick_nxt = 1'b1;
      end else begin
        fdiv_nxt = fdiv_r + 7'h01;
      end
    end
  end

  // Register stage of the divider
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fdiv_r        <= 7'h00;
      fast_clk_tick <= 1'b0;
    end else begin
      fdiv_r        <= fdiv_nxt;
      fast_clk_tick <= ftick_nxt;
    end
  end

  // ****************************************
  // Stabilisation timer
  // ****************************************
  logic              stab_start;
  logic [STAB_W-1:0] stab_len;
  logic              stab_tick;
  logic              stab_busy, stab_done;
  logic              wake_fast;

  // One timer serves both oscillators; only one waits at a time
  assign stab_tick = wake_fast ? fast_osc_tick : slow_osc_tick;

  omc_stab_timer #(
    .WIDTH (STAB_W)
  ) u_stab (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .start      (stab_start),
    .length     (stab_len),
    .tick       (stab_tick),
    .busy       (stab_busy),
    .done       (stab_done)
  );

  // ****************************************
  // Mode state machine
  // ****************************************
  omc_mode_t mode_nxt;
  logic      wake_fast_nxt;
  logic      key_change;
  logic      standby_wake;
  logic      halt_wake;

  // Key change: the key_change source, or any pad differing from its port register
  assign key_change = wake_src.key_change || (pad_levels != port_data);
  assign standby_wake = key_change || wake_src.ext_int || wake_src.timer_int ||
                        wake_src.real_timer_int || wake_src.key_strobe_int ||
                        wake_src.key_strobe_wake;
  assign halt_wake = key_change || wake_src.ext_int;

  // Next mode, and the wait length for the chosen clock
  always_comb begin
    mode_nxt      = mode;
    wake_fast_nxt = wake_fast;
    stab_start    = 1'b0;
    stab_len      = STAB_W'(`OMC_FAST_STAB_CYC);
    case (mode)
      OMC_NORMAL: begin
        if (sleep_req_r)
          mode_nxt = rtc_en_r ? OMC_STANDBY : OMC_HALT;
        else if (!clk_sel_r)
          mode_nxt = OMC_SLOW;
      end
      OMC_SLOW: begin
        if (sleep_req_r)
          mode_nxt = rtc_en_r ? OMC_STANDBY : OMC_HALT;
        else if (clk_sel_r) begin
          mode_nxt      = OMC_FAST_UP;
          wake_fast_nxt = 1'b1;
          stab_start    = 1'b1;
        end
      end
      OMC_STANDBY, OMC_HALT: begin
        if ((mode == OMC_STANDBY) ? standby_wake : halt_wake) begin
          mode_nxt      = OMC_WAKE;
          wake_fast_nxt = clk_sel_r;
          stab_start    = 1'b1;
          if (!clk_sel_r)
            stab_len = SLOW_XTAL ? STAB_W'(`OMC_XTAL_STAB_CYC)
                                 : STAB_W'(`OMC_IRC_STAB_CYC);
        end
      end
      OMC_WAKE, OMC_FAST_UP: begin
        if (stab_done)
          mode_nxt = wake_fast ? OMC_NORMAL : OMC_SLOW;
      end
      default: mode_nxt = OMC_NORMAL;
    endcase
  end

  // Register stage of the mode machine
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mode      <= OMC_NORMAL;
      wake_fast <= 1'b1;
    end else begin
      mode      <= mode_nxt;
      wake_fast <= wake_fast_nxt;
    end
  end

  // ****************************************
  // Clock gating outputs
  // ****************************************
  omc_clk_t clk_nxt;

  // Oscillator and CPU clock enables for the next mode
  always_comb begin
    clk_nxt = '0;
    case (mode_nxt)
      OMC_NORMAL: begin
        clk_nxt.fast_osc_en = 1'b1;
        clk_nxt.slow_osc_en = 1'b1;
        clk_nxt.cpu_clk_en  = 1'b1;
        clk_nxt.cpu_on_fast = 1'b1;
        clk_nxt.periph_en   = 1'b1;
      end
      OMC_SLOW: begin
        clk_nxt.slow_osc_en = 1'b1;
        clk_nxt.cpu_clk_en  = 1'b1;
        clk_nxt.periph_en   = 1'b1;
      end
      OMC_STANDBY: begin
        clk_nxt.slow_osc_en = 1'b1;
        clk_nxt.periph_en   = 1'b1;
      end
      OMC_HALT: clk_nxt = '0;
      OMC_WAKE, OMC_FAST_UP: begin
        clk_nxt.fast_osc_en = wake_fast_nxt;
        clk_nxt.slow_osc_en = 1'b1;
        clk_nxt.periph_en   = 1'b1;
      end
      default: clk_nxt = '0;
    endcase
  end

  // Register stage of the clock controls
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b)
      clk_ctrl <= '0;
    else
      clk_ctrl <= clk_nxt;
  end

  // ****************************************
  // Real-time clock divider
  // ****************************************
  logic rtc_run;

  // Halted when Halt stops the slow oscillator
  assign rtc_run = rtc_en_r && (mode != OMC_HALT);

  omc_rtc_div #(
    .WIDTH (RTC_W)
  ) u_rtc (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .enable     (rtc_run),
    .clear      (rtc_clr_r),
    .tick       (slow_osc_tick),
    .count      (rtc_count)
  );

endmodule : omc_ctrl

//--- hw/omc_pkg.sv
// Types shared by the operating mode controller modules.
// Assumes omc_cfg.svh is on the include path.
`include "omc_cfg.svh"

package omc_pkg;

  // Operating modes and wake transitions
  typedef enum logic [2:0] {
    OMC_NORMAL   = 3'h0,
    OMC_SLOW     = 3'h1,
    OMC_STANDBY  = 3'h2,
    OMC_HALT     = 3'h3,
    OMC_WAKE     = 3'h4,
    OMC_FAST_UP  = 3'h5
  } omc_mode_t;

  // Wake sources grouped together
  typedef struct packed {
    logic key_change;
    logic ext_int;
    logic timer_int;
    logic real_timer_int;
    logic key_strobe_int;
    logic key_strobe_wake;
  } omc_wake_t;

  // Clock gating outputs
  typedef struct packed {
    logic fast_osc_en;
    logic slow_osc_en;
    logic cpu_clk_en;
    logic cpu_on_fast;
    logic periph_en;
  } omc_clk_t;

endpackage : omc_pkg

//--- hw/omc_rtc_div.sv
// Real-time clock divider chain on the slow oscillator tick.
// Assumes slow tick is a one-cycle strobe in the clock domain.
`timescale 1ns/1ps

module omc_rtc_div #(
  parameter int WIDTH = 14
) (
  input  wire logic             clock,
  input  wire logic             rst_sync_b,
  input  wire logic             enable,
  input  wire logic             clear,
  input  wire logic             tick,
  output logic      [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_nxt;

  // Clear has priority; advance only on slow ticks while enabled
  always_comb begin
    count_nxt = count;
    if (clear)
      count_nxt = '0;
    else if (enable && tick)
      count_nxt = count + WIDTH'(1);
  end

  // Registers only
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b)
      count <= '0;
    else
      count <= count_nxt;
  end

endmodule : omc_rtc_div

//--- hw/omc_stab_timer.sv
// Stabilisation wait counter, counts qualified oscillator ticks.
// Assumes synchronous start pulse and tick strobe in the clock domain.
`timescale 1ns/1ps

module omc_stab_timer #(
  parameter int WIDTH = 11
) (
  input  wire logic             clock,
  input  wire logic             rst_sync_b,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] length,
  input  wire logic             tick,
  output logic                  busy,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_r, cnt_nxt;
  logic             busy_nxt, done_nxt;

  // Load on start, count down on ticks, pulse done at zero
  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt  = length;
      busy_nxt = 1'b1;
    end else if (busy && tick) begin
      if (cnt_r <= WIDTH'(1)) begin
        cnt_nxt  = '0;
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - WIDTH'(1);
      end
    end
  end

  // Registers only
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy  <= busy_nxt;
      done  <= done_nxt;
    end
  end

endmodule : omc_stab_timer

//--- test/omc_ctrl_properties.sv
// Port checker for the mode controller: sleep entry, wake waits, gating.
// Assumes oscillator ticks are one-cycle strobes synchronous to clock.
`timescale 1ns/1ps
`include "omc_cfg.svh"

module omc_ctrl_properties
  import omc_pkg::*;
#(
  parameter int STAB_W    = 11,
  parameter int RTC_W     = 14,
  parameter bit SLOW_XTAL = 1'b0
) (
  input wire logic               clock,
  input wire logic               rst_b,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic               fast_osc_tick,
  input wire logic               slow_osc_tick,
  input wire logic [7:0]         pad_levels,
  input wire logic [7:0]         port_data,
  input wire omc_pkg::omc_wake_t wake_src,
  input wire omc_pkg::omc_clk_t  clk_ctrl,
  input wire logic               fast_clk_tick,
  input wire omc_pkg::omc_mode_t mode,
  input wire logic [RTC_W-1:0]   rtc_count
);
  localparam int SLOW_CYC = SLOW_XTAL ? `OMC_XTAL_STAB_CYC : `OMC_IRC_STAB_CYC;
  logic [11:0] fcnt_r;
  logic [11:0] fcnt_nxt;
  logic [11:0] scnt_r;
  logic [11:0] scnt_nxt;
  logic        sleep_key;

  // ****
  // Helper logic
  // ****
  // Ticks seen during a wait; zero outside so each wait starts clean
  always_comb begin
    fcnt_nxt = 12'h000;
    scnt_nxt = 12'h000;
    if (mode == OMC_WAKE || mode == OMC_FAST_UP) begin
      fcnt_nxt = fcnt_r + {11'h000, fast_osc_tick};
      scnt_nxt = scnt_r + {11'h000, slow_osc_tick};
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fcnt_r <= 12'h000;
      scnt_r <= 12'h000;
    end else begin
      fcnt_r <= fcnt_nxt;
      scnt_r <= scnt_nxt;
    end
  end
  assign sleep_key = reg_wr && reg_addr == `OMC_OFS_SLEEP_CMD && reg_wdata == `OMC_SLEEP_KEY;

  // ****
  // Properties
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_reset_to_normal: assert property ($rose(rst_b) |-> ##[1:4] clk_ctrl == 5'h1F)
    else $error("clock gating not normal after reset");
  a_sleep_enters: assert property (sleep_key && mode inside {OMC_NORMAL, OMC_SLOW}
    |-> ##2 mode inside {OMC_STANDBY, OMC_HALT}) else $error("sleep key did not sleep");
  a_bad_key_ignored: assert property (reg_wr && reg_addr == `OMC_OFS_SLEEP_CMD
    && reg_wdata != `OMC_SLEEP_KEY && mode == OMC_NORMAL && !$past(reg_wr)
    |-> ##2 mode == OMC_NORMAL) else $error("wrong sleep code changed mode");
  a_halt_all_off: assert property (mode == OMC_HALT |-> !clk_ctrl.fast_osc_en
    && !clk_ctrl.slow_osc_en && !clk_ctrl.cpu_clk_en && !clk_ctrl.periph_en)
    else $error("clock running in halt");
  a_standby_gating: assert property (mode == OMC_STANDBY |-> !clk_ctrl.cpu_clk_en
    && !clk_ctrl.fast_osc_en && clk_ctrl.slow_osc_en) else $error("standby gating wrong");
  a_standby_wakes: assert property (mode == OMC_STANDBY
    && (wake_src != 6'h00 || pad_levels != port_data) |=> mode == OMC_WAKE)
    else $error("standby ignored a wake source");
  a_halt_holds: assert property (mode == OMC_HALT && !wake_src.key_change
    && !wake_src.ext_int && pad_levels == port_data |=> mode == OMC_HALT)
    else $error("halt left without its wake source");
  a_fast_wait: assert property ($past(mode) inside {OMC_WAKE, OMC_FAST_UP}
    && mode == OMC_NORMAL |-> fcnt_r >= 12'h200 && fcnt_r <= 12'h201)
    else $error("fast clock wait length wrong");
  a_slow_wait: assert property ($past(mode) == OMC_WAKE && mode == OMC_SLOW
    |-> scnt_r >= SLOW_CYC && scnt_r <= SLOW_CYC + 1) else $error("slow wait length wrong");
  a_no_tick_asleep: assert property ($past(mode) inside {OMC_STANDBY, OMC_HALT}
    |-> !fast_clk_tick) else $error("fast clock tick while asleep");
  a_bit2_reads_one: assert property (reg_rd && reg_addr == `OMC_OFS_MODE_CTRL
    |=> reg_rdata[`OMC_BIT_RTC_CLR]) else $error("clear bit read back low");
  a_rtc_clear: assert property (reg_wr && reg_addr == `OMC_OFS_MODE_CTRL
    && !reg_wdata[`OMC_BIT_RTC_CLR] |-> ##2 rtc_count <= 1) else $error("rtc not cleared");
  c_standby: cover property (mode == OMC_STANDBY);
  c_halt: cover property (mode == OMC_HALT);
  c_fast_up: cover property (mode == OMC_FAST_UP);
endmodule : omc_ctrl_properties

bind omc_ctrl omc_ctrl_properties #(.STAB_W(STAB_W), .RTC_W(RTC_W), .SLOW_XTAL(SLOW_XTAL))
  omc_ctrl_properties_i (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .fast_osc_tick(fast_osc_tick), .slow_osc_tick(slow_osc_tick), .pad_levels(pad_levels),
  .port_data(port_data), .wake_src(wake_src), .clk_ctrl(clk_ctrl),
  .fast_clk_tick(fast_clk_tick), .mode(mode), .rtc_count(rtc_count));

//--- test/tb.sv
// Self-checking bench for the mode controller: registers, sleep, wake, RTC.
// Assumes omc_ctrl and its checker are compiled before this file.
`timescale 1ns/1ps
`include "omc_cfg.svh"

module tb;
  import omc_pkg::*;
  logic        clock         = 1'b0;
  logic        rst_b         = 1'b0;
  logic [7:0]  reg_addr      = 8'h00;
  logic [7:0]  reg_wdata     = 8'h00;
  logic        reg_wr        = 1'b0;
  logic        reg_rd        = 1'b0;
  logic [7:0]  reg_rdata;
  logic        fast_osc_tick = 1'b0;
  logic        slow_osc_tick = 1'b0;
  logic [2:0]  slow_div      = 3'h0;
  logic [7:0]  pad_levels    = 8'h00;
  logic [7:0]  port_data     = 8'h00;
  omc_wake_t   wake_src      = 6'h00;
  omc_clk_t    clk_ctrl;
  logic        fast_clk_tick;
  omc_mode_t   mode;
  logic [13:0] rtc_count;
  int          miscompares   = 0;
  int          n_tests       = 0;

  always #2 clock = ~clock;

  // Oscillator strobes: fast every 2 cycles, slow every 8
  always @(posedge clock) begin
    fast_osc_tick <= ~fast_osc_tick;
    slow_div      <= slow_div + 3'h1;
    slow_osc_tick <= (slow_div == 3'h7);
  end

  omc_ctrl omc_ctrl_i (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fast_osc_tick(fast_osc_tick), .slow_osc_tick(slow_osc_tick), .pad_levels(pad_levels),
    .port_data(port_data), .wake_src(wake_src), .clk_ctrl(clk_ctrl),
    .fast_clk_tick(fast_clk_tick), .mode(mode), .rtc_count(rtc_count));

  // ****
  // Shared tasks
  // ****
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Lands 1 ns after the edge, so outputs of that edge are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // Trailing idle cycle keeps a strobe from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    cyc(1);
    reg_wr    <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    cyc(1);
    reg_rd   <= 1'b0;
    check("read data", reg_rdata, exp);
    cyc(1);
  endtask : rdchk

  task automatic wait_mode(input omc_mode_t m, output int n);
    n = 0;
    while (mode !== m) begin
      cyc(1);
      n++;
      if (n > 1500) begin
        miscompares++;
        $display("wrong value mode wait expected %0d seen %0d", m, mode);
        give_verdict();
      end
    end
  endtask : wait_mode

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    check("mode", mode, OMC_NORMAL);
    check("clock gating", clk_ctrl, 5'h1F);
    rdchk(`OMC_OFS_MODE_CTRL, 8'h8C);
    rdchk(`OMC_OFS_SLEEP_CMD, 8'h00);
    rdchk(8'h40, 8'h00);
  endtask : t_reset

  // Count pulses over 256 fast ticks, starting just after a pulse
  task automatic t_div();
    int n;
    int k;
    for (int d = 0; d < 8; d++) begin
      wr(`OMC_OFS_MODE_CTRL, 8'h8C | 8'(d << 4));
      rdchk(`OMC_OFS_MODE_CTRL, 8'h8C | 8'(d << 4));
      k = 0;
      while (fast_clk_tick !== 1'b1 && k < 600) begin
        cyc(1);
        k++;
      end
      if (fast_clk_tick !== 1'b1) begin
        miscompares++;
        $display("wrong value tick sync expected 1 seen 0");
        give_verdict();
      end
      n = 0;
      repeat (512) begin
        cyc(1);
        n += (fast_clk_tick === 1'b1);
      end
      check("tick count", n[13:0], 14'(256 >> d));
    end
  endtask : t_div

  task automatic t_slow();
    int n;
    // Slow strobe has run since time zero, so it is settled before the switch
    wr(`OMC_OFS_MODE_CTRL, 8'h0C);
    cyc(1);
    check("mode", mode, OMC_SLOW);
    cyc(1);
    check("fast osc enable", clk_ctrl.fast_osc_en, 1'b0);
    rdchk(`OMC_OFS_MODE_CTRL, 8'h0D);
    wr(`OMC_OFS_MODE_CTRL, 8'h8C);
    cyc(1);
    check("mode", mode, OMC_FAST_UP);
    wait_mode(OMC_NORMAL, n);
    check("fast wait", n >= 1015 && n <= 1030, 1'b1);
  endtask : t_slow

  // Source 6 is a pad mismatch, others a wake_src bit
  task automatic t_sleep(input logic [7:0] operating_mode_ctrl, input int src);
    omc_mode_t run;
    omc_mode_t sleep_command;
    int        n;
    run = operating_mode_ctrl[7] ? OMC_NORMAL : OMC_SLOW;
    sleep_command = operating_mode_ctrl[3] ? OMC_STANDBY : OMC_HALT;
    wr(`OMC_OFS_MODE_CTRL, operating_mode_ctrl);
    wait_mode(run, n);
    wr(`OMC_OFS_SLEEP_CMD, 8'hA5);
    cyc(1);
    check("mode", mode, run);
    wr(`OMC_OFS_SLEEP_CMD, `OMC_SLEEP_KEY);
    cyc(1);
    check("mode", mode, sleep_command);
    check("cpu clock", clk_ctrl.cpu_clk_en, 1'b0);
    check("slow osc", clk_ctrl.slow_osc_en, operating_mode_ctrl[3]);
    if (!operating_mode_ctrl[3]) begin
      wake_src <= 6'h0F;
      cyc(40);
      check("mode", mode, OMC_HALT);
    end
    if (src == 6) begin
      pad_levels <= 8'h01;
    end else begin
      wake_src <= 6'(1 << src);
    end
    wait_mode(run, n);
    check("wake wait", n >= (operating_mode_ctrl[7] ? 1015 : 25) && n <= (operating_mode_ctrl[7] ? 1035 : 45), 1'b1);
    wake_src   <= 6'h00; // strobe events quiet before the next sleep
    pad_levels <= 8'h00;
    cyc(1);
  endtask : t_sleep

  task automatic t_rtc();
    logic [13:0] r0;
    wr(`OMC_OFS_MODE_CTRL, 8'h8C);
    cyc(100);
    check("rtc running", rtc_count != 14'h0, 1'b1);
    wr(`OMC_OFS_MODE_CTRL, 8'h88);
    cyc(1);
    check("rtc cleared", rtc_count <= 14'h1, 1'b1);
    r0 = rtc_count;
    cyc(80);
    check("rtc rate", rtc_count - r0, 14'hA);
  endtask : t_rtc

  task automatic t_rst_sleep();
    wr(`OMC_OFS_SLEEP_CMD, `OMC_SLEEP_KEY);
    cyc(1);
    check("mode", mode, OMC_STANDBY);
    rst_b <= 1'b0;
    cyc(1);
    check("clock gating", clk_ctrl, 5'h00);
    rst_b <= 1'b1;
    cyc(4);
    check("mode", mode, OMC_NORMAL);
    check("clock gating", clk_ctrl, 5'h1F);
    rdchk(`OMC_OFS_MODE_CTRL, 8'h8C);
  endtask : t_rst_sleep

  // Main sequence: reset held two cycles, then every scenario
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    cyc(4);
    t_reset();
    t_div();
    t_slow();
    for (int s = 0; s < 7; s++) begin
      t_sleep(8'h8C, s);
    end
    t_sleep(8'h84, 5);
    t_sleep(8'h04, 4);
    t_sleep(8'h0C, 2);
    t_sleep(8'h84, 6);
    t_rtc();
    t_rst_sleep();
    give_verdict();
  end
endmodule : tb
